// ---- logic/iec_pkg.sv ----
package iec_pkg;

    // =========================================================
    // geometry
    localparam int NUM_PINS       = 4;
    localparam int TAG_W          = 16;
    localparam int FIFO_DEPTH     = 8;
    localparam int PTR_W          = 3;
    localparam int CNT_W          = 4;

    // =========================================================
    // timing, in state times (one state = one clock here)
    localparam logic [CNT_W-1:0] TIMER_PERIOD  = 4'h8;
    localparam logic [CNT_W-1:0] SAMPLE_PERIOD = 4'h9;
    localparam logic [CNT_W-1:0] SKIP_EVERY    = 4'h9;

    // =========================================================
    // reset values
    localparam logic [TAG_W-1:0] TAG_RESET = 16'h0000;

    typedef struct packed {
        logic [NUM_PINS-1:0] pins;
        logic [TAG_W-1:0]    tag;
    } iec_entry_t;

endpackage : iec_pkg

// ---- logic/iec_fifo.sv ----
`timescale 1ns/1ps
module iec_fifo (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rstSyncN,
    input  wire logic              clockEnable,
    // write side
    input  wire logic              push,
    input  iec_pkg::iec_entry_t    pushData,
    // read side
    input  wire logic              pop,
    output iec_pkg::iec_entry_t    popData,
    output logic                   empty,
    output logic                   full
);
    typedef struct packed {
        logic [iec_pkg::PTR_W-1:0] wrPtr;
        logic [iec_pkg::PTR_W-1:0] rdPtr;
        logic [iec_pkg::PTR_W:0]   count;
    } iec_fifo_state_t;

    iec_fifo_state_t     st;
    iec_fifo_state_t     next_st;
    iec_pkg::iec_entry_t mem [iec_pkg::FIFO_DEPTH];
    logic                doPush;
    logic                doPop;

    assign empty   = (st.count == '0);
    assign full    = (st.count == (iec_pkg::PTR_W+1)'(iec_pkg::FIFO_DEPTH));
    assign popData = mem[st.rdPtr];
    // a push into a full fifo is dropped; the entry is lost
    assign doPush  = push && !full;
    assign doPop   = pop && !empty;

    always_comb begin
        next_st = st;
        if (doPush) begin
            next_st.wrPtr = st.wrPtr + 1'b1;
        end
        if (doPop) begin
            next_st.rdPtr = st.rdPtr + 1'b1;
        end
        next_st.count = st.count + {3'h0, doPush} - {3'h0, doPop};
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st <= '0;
        end else if (clockEnable) begin
            st <= next_st;
        end
    end

    always_ff @(posedge clock) begin
        if (clockEnable && doPush) begin
            mem[st.wrPtr] <= pushData;
        end
    end
endmodule : iec_fifo

// ---- logic/iec_capture.sv ----
`timescale 1ns/1ps
module iec_capture (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rstn,
    input  wire logic                      clockEnable,
    // capture pins
    input  wire logic [iec_pkg::NUM_PINS-1:0] eventCaptureInput,
    // holding register read side
    input  wire logic                      holdRead,
    output logic                           holdValid,
    output iec_pkg::iec_entry_t            holdEntry,
    // status
    output logic [iec_pkg::TAG_W-1:0]      timerValue,
    output logic                           fifoFull
);
    // =========================================================
    // reset release
    logic rstMeta;
    logic rstSyncN;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // =========================================================
    // state
    typedef enum {IEC_IDLE, IEC_RUN} iec_mode_t;

    typedef struct packed {
        logic [iec_pkg::CNT_W-1:0]    prescale;
        logic [iec_pkg::CNT_W-1:0]    sampleCnt;
        logic [iec_pkg::CNT_W-1:0]    skipCnt;
        logic [iec_pkg::TAG_W-1:0]    timer;
        logic [iec_pkg::NUM_PINS-1:0] lastPins;
        logic                         holdValid;
        iec_pkg::iec_entry_t          hold;
        logic                         fifoFull;
        logic                         primed;
    } iec_state_t;

    iec_state_t          st;
    iec_state_t          next_st;
    iec_mode_t           mode;
    iec_mode_t           next_mode;
    logic                sampleTick;
    logic [iec_pkg::NUM_PINS-1:0] edges;
    logic                anyEvent;
    iec_pkg::iec_entry_t newEntry;
    logic                fifoPush;
    logic                fifoPop;
    iec_pkg::iec_entry_t fifoOut;
    logic                fifoEmpty;
    logic                fifoFullW;

    // =========================================================
    // sampling: one look at the pins per nine states
    assign sampleTick = (st.sampleCnt == iec_pkg::SAMPLE_PERIOD - 4'h1);
    // only the level at the sample matters, so an even number of
    // toggles inside one interval vanishes without a trace
    assign edges    = eventCaptureInput ^ st.lastPins;
    // all pins changing in one sample form one entry with one tag
    assign anyEvent = sampleTick && (edges != '0) && (mode == IEC_RUN);
    assign newEntry = '{pins: edges, tag: st.timer};

    // event goes to holding only if holding and fifo are both empty
    assign fifoPush = anyEvent && (st.holdValid || !fifoEmpty);
    assign fifoPop  = !fifoEmpty && (!st.holdValid || holdRead);

    iec_fifo uFifo (
        .clock       (clock),
        .rstSyncN    (rstSyncN),
        .clockEnable (clockEnable),
        .push        (fifoPush),
        .pushData    (newEntry),
        .pop         (fifoPop),
        .popData     (fifoOut),
        .empty       (fifoEmpty),
        .full        (fifoFullW)
    );

    always_comb begin
        next_st   = st;
        next_mode = mode;
        case (mode)
            IEC_IDLE: begin
                // first state after reset only captures the pin levels
                next_mode = IEC_RUN;
            end
            IEC_RUN: begin
                next_mode = IEC_RUN;
            end
            default: begin
                next_mode = IEC_IDLE;
            end
        endcase
        next_st.sampleCnt = sampleTick ? '0 : st.sampleCnt + 4'h1;
        if (sampleTick || mode == IEC_IDLE) begin
            next_st.lastPins = eventCaptureInput;
        end
        // timer counts every eight states; a skip every nine counts
        if (st.prescale == iec_pkg::TIMER_PERIOD - 4'h1) begin
            next_st.prescale = '0;
            if (st.skipCnt == iec_pkg::SKIP_EVERY - 4'h1) begin
                next_st.skipCnt = '0;
                next_st.timer   = st.timer + 16'h0002;
            end else begin
                next_st.skipCnt = st.skipCnt + 4'h1;
                next_st.timer   = st.timer + 16'h0001;
            end
        end else begin
            next_st.prescale = st.prescale + 4'h1;
        end
        // holding register
        if (holdRead && st.holdValid) begin
            next_st.holdValid = 1'b0;
        end
        if (fifoPop) begin
            next_st.hold      = fifoOut;
            next_st.holdValid = 1'b1;
        end else if (anyEvent && !fifoPush && (!st.holdValid || holdRead)) begin
            next_st.hold      = newEntry;
            next_st.holdValid = 1'b1;
        end
        if (anyEvent) begin
            next_st.primed = 1'b1;
        end
        next_st.fifoFull = fifoFullW;
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st       <= '0;
            st.timer <= iec_pkg::TAG_RESET;
            mode     <= IEC_IDLE;
        end else if (clockEnable) begin
            st   <= next_st;
            mode <= next_mode;
        end
    end

    assign holdValid  = st.holdValid;
    assign holdEntry  = st.hold;
    assign timerValue = st.timer;
    assign fifoFull   = st.fifoFull;

    // =========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSyncN || !clockEnable);

    chk_sample_period: assert property (sampleTick |=> !sampleTick [*8])
        else $error("sample ticks closer than nine states");
    chk_sample_gap: assert property (sampleTick |-> ##9 sampleTick)
        else $error("sample interval not nine states");
    chk_timer_step: assert property ($changed(st.timer) |=> $stable(st.timer) [*7])
        else $error("timer moved faster than every eight states");
    chk_tag_skip: assert property ($changed(st.timer) |->
            (st.timer - $past(st.timer)) inside {16'h0001, 16'h0002})
        else $error("timer step not one or two");
    chk_first_hold: assert property (anyEvent && !st.holdValid && fifoEmpty |=>
            holdValid && holdEntry.tag == $past(st.timer))
        else $error("first event not placed in holding register");
    chk_second_fifo: assert property (anyEvent && st.holdValid && !holdRead && fifoEmpty
            |=> !fifoEmpty)
        else $error("second event not written into fifo");
    // coincident pin changes into an empty path must not leave a second entry behind
    chk_one_entry: assert property (anyEvent && !st.holdValid && fifoEmpty |=> fifoEmpty)
        else $error("coincident events split");
    chk_hold_advance: assert property (holdRead && st.holdValid && !fifoEmpty |=>
            holdValid && holdEntry == $past(fifoOut))
        else $error("fifo head not advanced into holding");
    chk_no_event_idle: assert property (mode == IEC_IDLE |-> !anyEvent)
        else $error("event recorded before first sample");

    cov_first_event: cover property (anyEvent && !st.holdValid);
    cov_fifo_write: cover property (fifoPush);
    cov_two_pins: cover property (anyEvent && $countones(edges) > 1);
    cov_skip_tag: cover property (st.skipCnt == iec_pkg::SKIP_EVERY - 4'h1 && anyEvent);
endmodule : iec_capture

// ---- test/iec_pin_model.sv ----
`timescale 1ns/1ps
// =========================================================
// far side: capture pins that hold their level between toggles
module iec_pin_model (
    // clock
    input  wire logic                         clock,
    // command from the bench, one bit per pin
    input  wire logic [iec_pkg::NUM_PINS-1:0] toggleMask,
    // pin levels
    output logic      [iec_pkg::NUM_PINS-1:0] pins
);
    initial pins = 4'h0;
    // pins only move at clock edges, so they act as synchronous levels
    // plain always, since the initial block above also sets the level
    always @(posedge clock) begin
        pins <= pins ^ toggleMask;
    end
endmodule : iec_pin_model

// ---- test/input_event_timestamp_capture_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module input_event_timestamp_capture_tb;
    logic                         clock = 1'b0;
    logic                         rstn = 1'b0;
    logic                         clockEnable = 1'b1;
    logic                         holdRead = 1'b0;
    logic [iec_pkg::NUM_PINS-1:0] toggleMask = 4'h0;
    logic [iec_pkg::NUM_PINS-1:0] pins;
    logic                         holdValid;
    iec_pkg::iec_entry_t          holdEntry;
    logic [iec_pkg::TAG_W-1:0]    timerValue;
    logic                         fifoFull;
    logic [iec_pkg::TAG_W-1:0]    prevTag;
    logic [3:0]                   rowMask [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hF};
    int                           bad_count = 0;
    int                           n_checks = 0;
    int                           drained;
    always #2.5 clock = ~clock;
    iec_pin_model iec_pin_model_inst (.clock(clock), .toggleMask(toggleMask), .pins(pins));
    iec_capture iec_capture_inst (.clock(clock), .rstn(rstn), .clockEnable(clockEnable),
        .eventCaptureInput(pins), .holdRead(holdRead), .holdValid(holdValid),
        .holdEntry(holdEntry), .timerValue(timerValue), .fifoFull(fifoFull));
    // =========================================================
    // helpers
    task report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task pulse(input logic [3:0] mask);
        toggleMask <= mask;
        @(posedge clock);
        toggleMask <= 4'h0;
        tick(1);
    endtask : pulse
    task readHold();
        holdRead <= 1'b1;
        @(posedge clock);
        holdRead <= 1'b0;
        tick(1);
    endtask : readHold
    task waitHold();
        int i;
        for (i = 0; i < 40 && holdValid !== 1'b1; i++) tick(1);
        if (holdValid !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
    endtask : waitHold
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    // =========================================================
    // main sequence
    initial begin
        tick(16);
        rstn <= 1'b1;
        tick(4);
        `CHK(holdValid, 1'b0)
        `CHK(fifoFull, 1'b0)
        tick(20);
        prevTag = 16'h0000;
        foreach (rowMask[r]) begin
            pulse(rowMask[r]);
            waitHold();
            `CHK(holdEntry.pins, rowMask[r])
            `CHK(holdEntry.tag > prevTag, 1'b1)
            prevTag = holdEntry.tag;
            readHold();
            `CHK(holdValid, 1'b0)
        end
        // second event lands in the fifo and follows on read
        pulse(4'h1);
        tick(12);
        pulse(4'h2);
        waitHold();
        `CHK(holdEntry.pins, 4'h1)
        prevTag = holdEntry.tag;
        tick(20);
        readHold();
        `CHK(holdValid, 1'b1)
        `CHK(holdEntry.pins, 4'h2)
        `CHK(holdEntry.tag - prevTag >= 16'h0001, 1'b1)
        readHold();
        // nine steps of the timer always include exactly one skipped tag
        prevTag = timerValue;
        tick(72);
        `CHK(timerValue - prevTag, 16'h000A)
        // holding plus eight fifo slots, the tenth event is dropped
        for (int i = 0; i < 10; i++) begin
            pulse(4'(4'h1 << (i % 4)));
            tick(10);
        end
        `CHK(fifoFull, 1'b1)
        drained = 0;
        for (int i = 0; i < 12 && holdValid === 1'b1; i++) begin
            readHold();
            drained++;
        end
        `CHK(drained, 9)
        `CHK(fifoFull, 1'b0)
        // a disabled clock freezes timer and capture
        clockEnable <= 1'b0;
        tick(1);
        prevTag = timerValue;
        pulse(4'h4);
        tick(30);
        `CHK(timerValue, prevTag)
        `CHK(holdValid, 1'b0)
        clockEnable <= 1'b1;
        waitHold();
        `CHK(holdEntry.pins, 4'h4)
        readHold();
        // reset in mid-run clears everything
        pulse(4'h8);
        rstn <= 1'b0;
        tick(2);
        `CHK(holdValid, 1'b0)
        `CHK(timerValue, 16'h0000)
        rstn <= 1'b1;
        tick(16);
        // pin level left from before reset is only latched, never an event
        `CHK(holdValid, 1'b0)
        `CHK(fifoFull, 1'b0)
        report_and_stop();
    end
endmodule : input_event_timestamp_capture_tb
